// [hw/pfs_pkg.sv]
// Constants and carrier types for the power-fail supervisor
package pfs_pkg;

    localparam logic [7:0] WARN_VECTOR      = 8'h2B;
    localparam int         SYNC_WIDTH       = 4;
    localparam int         CS_COUNT         = 4;
    localparam int         PE_COUNT         = 4;
    localparam logic       STROBE_IDLE      = 1'h1;
    localparam logic       PIN_DRIVE_LEVEL  = 1'h0;
    localparam int         POS_BELOW_WARN   = 0;
    localparam int         POS_BELOW_RUN    = 1;
    localparam int         POS_BELOW_BACKUP = 2;
    localparam int         POS_PIN          = 3;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WARN,
        ST_RESET,
        ST_BACKUP
    } supply_state_e;

    typedef struct packed {
        logic below_warning;
        logic below_run;
        logic below_backup;
    } supply_s;

    typedef struct packed {
        logic [CS_COUNT-1:0] chip_select_n;
        logic [PE_COUNT-1:0] periph_select_n;
        logic                write_n;
    } strobe_s;

    localparam strobe_s STROBE_OFF = '{
        chip_select_n:   {CS_COUNT{STROBE_IDLE}},
        periph_select_n: {PE_COUNT{STROBE_IDLE}},
        write_n:         STROBE_IDLE
    };

    typedef struct packed {
        supply_state_e state;
        logic          warn_prev;
        logic          int_pend;
        logic [7:0]    vector;
        logic          hold_reset;
        logic          pin_oe_b;
        logic          backup_n;
        strobe_s       strobe;
    } sup_state_s;

endpackage

// [hw/pfs_sync.sv]
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/100ps
module pfs_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_b_i,
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] init_i,
    output logic      [W-1:0] q_o
);
    // First stage feeds only the second stage
    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    always_comb begin
        next_meta = d_i;
        next_q    = meta;
    end

    // Reset value is all zeros; init_i from the parent is not used for reset
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            meta <= '0;
            q_o  <= '0;
        end else begin
            meta <= next_meta;
            q_o  <= next_q;
        end
    end

    logic unused_init;
    assign unused_init = ^init_i;
endmodule

// [hw/power_fail_supervisor.sv]
// Power-fail supervisor: warning interrupt, supply reset, strobe forcing and backup switchover
// Function
// RL1 - Supply below warning threshold with interrupt enabled vectors to address 2Bh.
// RL2 - Between warning and run thresholds the processor keeps running normally.
// RL3 - At run threshold, hold reset until supply rises back above it.
// RL4 - In low-supply reset all chip selects and write strobe are forced high.
// RL5 - Below backup threshold switch to backup cell and power down most circuits.
// RL6 - Drive reset-status pin low while supply is low and processor in reset.
// RL7 - Reset-status pin pulled low outside is a reset request; peers may share it.
// RL8 - Drive backup-active output low while running from the backup cell.
// RL9 - Reset-status and backup-active outputs stay valid with main supply at 0V.
// RL10 - Backup cell loaded only below backup threshold, otherwise never drawn.
// RL11 - Battery-backed chip selects stay inactive high below backup threshold.
// RL12 - Threshold inputs synchronised first; warning interrupt gated by an enable bit.
`timescale 1ns/100ps
module power_fail_supervisor (
    input  wire logic            clk_i,
    input  wire logic            rst_b_i,
    input  pfs_pkg::supply_s     supply_i,
    input  wire logic            warn_int_en_i,
    input  wire logic            int_ack_i,
    input  pfs_pkg::strobe_s     strobe_i,
    input  wire logic            reset_status_pin_i,
    output logic                 reset_status_pin_o,
    output logic                 reset_status_pin_oe_b_o,
    output logic                 backup_active_n_o,
    output logic                 backup_switch_o,
    output logic                 core_power_down_o,
    output logic                 battery_load_o,
    output logic                 cpu_reset_o,
    output logic                 int_req_o,
    output logic [7:0]           int_vector_o,
    output pfs_pkg::strobe_s     strobe_o
);

    localparam pfs_pkg::sup_state_s RESET_STATE = '{
        state:      pfs_pkg::ST_RESET,
        warn_prev:  1'h0,
        int_pend:   1'h0,
        vector:     8'h00,
        hold_reset: 1'h1,
        pin_oe_b:   1'h0,
        backup_n:   1'h1,
        strobe:     pfs_pkg::STROBE_OFF
    };

    pfs_pkg::sup_state_s st;
    pfs_pkg::sup_state_s next_st;
    pfs_pkg::supply_s    sup;
    logic [pfs_pkg::SYNC_WIDTH-1:0] raw_in;
    logic [pfs_pkg::SYNC_WIDTH-1:0] synced;
    logic                pin_low;
    logic                ext_req;
    logic                warn_edge;
    logic                forced;

    // Comparators and the shared pin are asynchronous to this clock
    always_comb begin
        raw_in = '0;
        raw_in[pfs_pkg::POS_BELOW_WARN]   = supply_i.below_warning;
        raw_in[pfs_pkg::POS_BELOW_RUN]    = supply_i.below_run;
        raw_in[pfs_pkg::POS_BELOW_BACKUP] = supply_i.below_backup;
        // Pin is synchronised as a plain level, so its reset value of 0 reads as "pin low",
        // which matches our own drive during reset
        raw_in[pfs_pkg::POS_PIN]          = reset_status_pin_i;
    end

    pfs_sync #(
        .W(pfs_pkg::SYNC_WIDTH)
    ) u_sync (                                                       // [RL12]
        .clk_i  (clk_i),
        .rst_b_i(rst_b_i),
        .d_i    (raw_in),
        .init_i ('0),
        .q_o    (synced)
    );

    always_comb begin
        sup.below_warning = synced[pfs_pkg::POS_BELOW_WARN];
        sup.below_run     = synced[pfs_pkg::POS_BELOW_RUN];
        sup.below_backup  = synced[pfs_pkg::POS_BELOW_BACKUP];
        pin_low           = ~synced[pfs_pkg::POS_PIN];
    end

    // Own drive is masked; after release the pin echo can stretch reset by three cycles
    assign ext_req   = pin_low & st.pin_oe_b;                        // [RL7]
    assign warn_edge = sup.below_warning & ~st.warn_prev;

    always_comb begin
        next_st = st;
        next_st.warn_prev = sup.below_warning;
        case (st.state)
            pfs_pkg::ST_RUN: begin
                if (sup.below_backup) begin
                    next_st.state = pfs_pkg::ST_BACKUP;              // [RL5]
                end else if (sup.below_run) begin
                    next_st.state = pfs_pkg::ST_RESET;               // [RL3]
                end else if (sup.below_warning) begin
                    next_st.state = pfs_pkg::ST_WARN;
                end
            end
            pfs_pkg::ST_WARN: begin
                if (sup.below_backup) begin
                    next_st.state = pfs_pkg::ST_BACKUP;
                end else if (sup.below_run) begin
                    next_st.state = pfs_pkg::ST_RESET;
                end else if (!sup.below_warning) begin
                    next_st.state = pfs_pkg::ST_RUN;
                end
            end
            pfs_pkg::ST_RESET: begin
                if (sup.below_backup) begin
                    next_st.state = pfs_pkg::ST_BACKUP;
                end else if (!sup.below_run) begin
                    next_st.state = sup.below_warning ? pfs_pkg::ST_WARN
                                                      : pfs_pkg::ST_RUN;  // [RL3]
                end
            end
            pfs_pkg::ST_BACKUP: begin
                if (!sup.below_backup) begin
                    next_st.state = pfs_pkg::ST_RESET;
                end
            end
            default: begin
                next_st.state = pfs_pkg::ST_RESET;
            end
        endcase

        forced = (next_st.state == pfs_pkg::ST_RESET) ||
                 (next_st.state == pfs_pkg::ST_BACKUP);

        // Warning state keeps the core running; only supply or the pin resets it
        // Echo of our own drive keeps the core held, so release gives no reset pulse
        next_st.hold_reset = forced | ext_req | (pin_low & ~st.pin_oe_b);  // [RL3] [RL7]

        // Set wins over acknowledge; a supply reset or backup drops a pending warning
        if (forced) begin
            next_st.int_pend = 1'h0;
        end else if (warn_edge && warn_int_en_i) begin
            next_st.int_pend = 1'h1;                                 // [RL1] [RL12]
        end else if (int_ack_i) begin
            next_st.int_pend = 1'h0;
        end
        next_st.vector = next_st.int_pend ? pfs_pkg::WARN_VECTOR : 8'h00;  // [RL1]

        next_st.pin_oe_b = ~forced;                                  // [RL6]
        next_st.backup_n = (next_st.state != pfs_pkg::ST_BACKUP);    // [RL8]
        next_st.strobe   = forced ? pfs_pkg::STROBE_OFF : strobe_i;  // [RL4] [RL11]
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st <= RESET_STATE;
        end else begin
            st <= next_st;
        end
    end

    // These two pins sit in the backup-powered part, so they hold level at 0V main supply
    assign reset_status_pin_o      = pfs_pkg::PIN_DRIVE_LEVEL;       // [RL9]
    assign reset_status_pin_oe_b_o = st.pin_oe_b;                    // [RL9]
    assign backup_active_n_o       = st.backup_n;                    // [RL9]
    assign backup_switch_o         = ~st.backup_n;                   // [RL5]
    assign core_power_down_o       = ~st.backup_n;                   // [RL5]
    // Cell is tapped only through the switchover path, never above the threshold
    assign battery_load_o          = ~st.backup_n;                   // [RL10]
    assign cpu_reset_o             = st.hold_reset;
    assign int_req_o               = st.int_pend;
    assign int_vector_o            = st.vector;
    assign strobe_o                = st.strobe;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    a_warn_vector: assert property (                                 // [RL1]
        $rose(int_req_o) |-> int_vector_o == pfs_pkg::WARN_VECTOR &&
                             $past(sup.below_warning) && !$past(st.warn_prev)
    ) else $error("warning interrupt without vector or edge");

    a_warn_keeps_run: assert property (                              // [RL2]
        (st.state == pfs_pkg::ST_WARN && !$past(pin_low)) |-> !cpu_reset_o
    ) else $error("core reset while only in warning band");

    a_low_holds_reset: assert property (                             // [RL3]
        sup.below_run |=> cpu_reset_o && st.state != pfs_pkg::ST_RUN &&
                          st.state != pfs_pkg::ST_WARN
    ) else $error("core not held in reset at low supply");

    a_strobes_forced: assert property (                              // [RL4]
        (st.state == pfs_pkg::ST_RESET) |-> strobe_o == pfs_pkg::STROBE_OFF
    ) else $error("strobe active during supply reset");

    a_backup_switch: assert property (                               // [RL5]
        sup.below_backup |=> backup_switch_o && core_power_down_o &&
                             st.state == pfs_pkg::ST_BACKUP
    ) else $error("no switchover below backup threshold");

    a_pin_driven: assert property (                                  // [RL6]
        sup.below_run |=> !reset_status_pin_oe_b_o && cpu_reset_o
    ) else $error("reset status pin not driven at low supply");

    a_ext_reset: assert property (                                   // [RL7]
        (pin_low && reset_status_pin_oe_b_o) |=> cpu_reset_o
    ) else $error("outside pull on status pin did not reset core");

    a_backup_flag: assert property (                                 // [RL8]
        (sup.below_backup ##1 sup.below_backup) |-> !backup_active_n_o
    ) else $error("backup flag high while on backup cell");

    a_cell_idle: assert property (                                   // [RL10]
        battery_load_o |-> $past(sup.below_backup)
    ) else $error("backup cell loaded above backup threshold");

    a_backed_cs_off: assert property (                               // [RL11]
        (st.state == pfs_pkg::ST_BACKUP) |-> &strobe_o.chip_select_n &&
                                             &strobe_o.periph_select_n
    ) else $error("backed chip select active in backup");

    a_int_gated: assert property (                                   // [RL12]
        $rose(int_req_o) |-> $past(warn_int_en_i)
    ) else $error("warning interrupt raised while disabled");

endmodule

// [dv/pfs_partner.sv]
// Supply comparators and a peer part that can pull the shared reset pin
`timescale 1ns/100ps
module pfs_partner (
    input  wire logic [1:0]  level_i,
    input  wire logic        peer_pull_i,
    input  wire logic        drv_i,
    input  wire logic        oe_b_i,
    output pfs_pkg::supply_s supply_o,
    output logic             pin_o
);
    // Level 0 good, 1 below warning, 2 below run, 3 below backup
    // Thresholds nest, so a lower crossing always implies the upper ones
    assign supply_o.below_warning = (level_i >= 2'h1);
    assign supply_o.below_run     = (level_i >= 2'h2);
    assign supply_o.below_backup  = (level_i == 2'h3);
    // Open drain with pull-up: any party pulling low wins
    assign pin_o = (peer_pull_i || (!oe_b_i && !drv_i)) ? 1'h0 : 1'h1;
endmodule

// [dv/power_fail_supervisor_test.sv]
// Self-checking bench for the power-fail supervisor
`timescale 1ns/100ps
module power_fail_supervisor_test;
    logic             clk_i = 1'h0;
    logic             rst_b_i = 1'h0;
    logic [1:0]       level = 2'h0;
    logic             peer_pull = 1'h0;
    logic             en = 1'h0;
    logic             ack = 1'h0;
    pfs_pkg::strobe_s stb = pfs_pkg::strobe_s'(9'h0A5);
    pfs_pkg::supply_s sup;
    pfs_pkg::strobe_s stb_o;
    logic             pin, drv, oe_b, bk_n, sw, pd, load, cpu_rst, irq;
    logic [7:0]       vec;
    int               errors = 0;
    int               cmp_count = 0;

    always #20 clk_i = ~clk_i;

    pfs_partner pfs_partner_inst (.level_i(level), .peer_pull_i(peer_pull), .drv_i(drv),
        .oe_b_i(oe_b), .supply_o(sup), .pin_o(pin));

    power_fail_supervisor power_fail_supervisor_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
        .supply_i(sup), .warn_int_en_i(en), .int_ack_i(ack), .strobe_i(stb),
        .reset_status_pin_i(pin), .reset_status_pin_o(drv), .reset_status_pin_oe_b_o(oe_b),
        .backup_active_n_o(bk_n), .backup_switch_o(sw), .core_power_down_o(pd),
        .battery_load_o(load), .cpu_reset_o(cpu_rst), .int_req_o(irq),
        .int_vector_o(vec), .strobe_o(stb_o));

    task chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task set_level(input logic [1:0] v);
        @(posedge clk_i);
        level <= v;
    endtask

    // Own release echoes back through the pin, so allow a few extra edges
    task wait_release;
        for (int i = 0; i < 10 && cpu_rst !== 1'h0; i++) tick(1);
        chk(cpu_rst, 1'h0);
        chk(oe_b, 1'h1);
    endtask

    task t_warning;
        en <= 1'h1;
        set_level(2'h1);
        tick(3);
        chk({irq, vec}, {1'h1, pfs_pkg::WARN_VECTOR});
        chk(cpu_rst, 1'h0);
        chk(stb_o, stb);
        @(posedge clk_i);
        ack <= 1'h1;
        @(posedge clk_i);
        ack <= 1'h0;
        #1;
        chk({irq, vec}, 9'h000);
        chk(cpu_rst, 1'h0);
        set_level(2'h0);
        tick(3);
        en <= 1'h0;
        set_level(2'h1);
        tick(4);
        chk(irq, 1'h0);
        set_level(2'h0);
        tick(3);
    endtask

    task t_run_low;
        en <= 1'h1;
        set_level(2'h2);
        tick(3);
        chk(cpu_rst, 1'h1);
        chk({oe_b, drv, pin}, 3'h0);
        chk(stb_o, pfs_pkg::STROBE_OFF);
        chk(irq, 1'h0);
        stb <= pfs_pkg::strobe_s'(9'h000);
        tick(12);
        chk(stb_o, pfs_pkg::STROBE_OFF);
        chk(cpu_rst, 1'h1);
        chk(bk_n, 1'h1);
        set_level(2'h0);
        wait_release;
        tick(1);
        chk(stb_o, stb);
        stb <= pfs_pkg::strobe_s'(9'h0A5);
    endtask

    task t_backup;
        set_level(2'h2);
        tick(3);
        chk({sw, pd, load}, 3'h0);
        set_level(2'h3);
        tick(3);
        chk(bk_n, 1'h0);
        chk({sw, pd, load}, 3'h7);
        chk(stb_o, pfs_pkg::STROBE_OFF);
        chk({cpu_rst, oe_b}, 2'h2);
        set_level(2'h0);
        tick(3);
        chk({bk_n, sw, pd, load}, 4'h8);
        wait_release;
    endtask

    task t_peer;
        @(posedge clk_i);
        peer_pull <= 1'h1;
        tick(3);
        chk({cpu_rst, oe_b}, 2'h3);
        @(posedge clk_i);
        peer_pull <= 1'h0;
        tick(3);
        chk(cpu_rst, 1'h0);
    endtask

    task report_and_stop;
        $display("comparisons %0d errors %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // Whole sequence needs under a hundred cycles; the 3000-cycle limit leaves wide margin
    initial begin
        #(3000 * 40);
        errors++;
        report_and_stop;
    end

    initial begin
        tick(6);
        chk({cpu_rst, oe_b, bk_n}, 3'h5);
        chk(stb_o, pfs_pkg::STROBE_OFF);
        @(posedge clk_i);
        rst_b_i <= 1'h1;
        tick(1);
        wait_release;
        t_warning;
        t_run_low;
        t_backup;
        t_peer;
        report_and_stop;
    end
endmodule
